// ===== tdfr_defs.svh
// Offsets, field positions, reset values and timing counts of the torque detect / fault restart block
`ifndef TDFR_DEFS_SVH
`define TDFR_DEFS_SVH
`define TDFR_OFS_CTRL 8'h00
`define TDFR_OFS_LEVEL 8'h04
`define TDFR_OFS_TIME 8'h08
`define TDFR_OFS_IVL 8'h0c
`define TDFR_OFS_MFO 8'h10
`define TDFR_OFS_STAT 8'h14
`define TDFR_F_SEL 3:0
`define TDFR_F_FOSEL 4
`define TDFR_F_LIMIT 11:8
`define TDFR_F_TREF 12
`define TDFR_F_ANA 20:16
`define TDFR_F_LEVEL 8:0
`define TDFR_F_TIME 6:0
`define TDFR_F_IVL 12:0
`define TDFR_F_MFO0 4:0
`define TDFR_F_MFO1 12:8
`define TDFR_F_ST 10:8
`define TDFR_F_CNT 15:12
`define TDFR_F_DCNT 22:16
`define TDFR_F_MOUT 25:24
`define TDFR_SEL_MAX 4'h8
`define TDFR_LEVEL_RST 9'h096
`define TDFR_LEVEL_MAX 9'h12c
`define TDFR_BAND 11'h00a
`define TDFR_TIME_RST 7'h01
`define TDFR_TIME_MAX 7'h64
`define TDFR_IVL_RST 13'h0064
`define TDFR_IVL_MIN 13'h0005
`define TDFR_IVL_MAX 13'h1770
`define TDFR_LIMIT_MAX 4'ha
`define TDFR_FN_FAULT 5'h0b
`define TDFR_FN_RESTART 5'h0e
`define TDFR_FN_DET1 5'h12
`define TDFR_FN_DET2 5'h14
`define TDFR_ANA_LEVEL1 5'h0b
`define TDFR_CLK_NS 40
`define TDFR_TENTH_NS 100000000
`define TDFR_NORMAL_MIN 10
`define TDFR_NORMAL_TENTHS (13'(`TDFR_NORMAL_MIN * 600))
`define TDFR_RESP_OKAY 2'h0
`define TDFR_RESP_SLVERR 2'h2
`endif

// ===== tdfr_pkg.sv
// Types shared by the torque detect / fault restart block
package tdfr_pkg;

typedef enum logic [2:0] {
    ST_IDLE, ST_WITHDRAW, ST_WAIT, ST_DIAG, ST_SEARCH, ST_RUNNING, ST_LOCKOUT
} tdfr_seq_e;

typedef struct packed {
    logic runCmd;
    logic speedAgree;
    logic [9:0] current;
    logic [9:0] torque;
} tdfr_core_s;

typedef struct packed {
    logic awHeld;
    logic wHeld;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [3:0] sel;
    logic foSel;
    logic [3:0] limit;
    logic torqueRef;
    logic [4:0] anaFunc;
    logic [8:0] level;
    logic [6:0] dtime;
    logic [12:0] ivl;
    logic [4:0] mfo0;
    logic [4:0] mfo1;
    logic det1;
    logic [6:0] detCnt;
    tdfr_seq_e st;
    logic [3:0] cnt;
    logic [12:0] tmr;
    logic runWithdraw;
    logic speedSearch;
    logic driveStop;
    logic otEvt;
    logic utEvt;
    logic faultOut;
    logic restartAct;
    logic [1:0] mfoOut;
} tdfr_state_s;

endpackage

// ===== tdfr_tick.sv
// Tenth-of-a-second tick generator with a phase restart
`timescale 1ns/1ns
module tdfr_tick #(
    parameter int unsigned PERIOD = 2500000
) (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // Phase restart and tick
    input wire clr,
    output logic tick
);
    localparam int W = $clog2(PERIOD + 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } tdfr_tick_s;

    tdfr_tick_s s;
    tdfr_tick_s n;

    always_comb begin
        n = s;
        n.tick = 1'b0;
        if (clr) begin
            n.cnt = '0;
        end else if (s.cnt == W'(PERIOD - 1)) begin
            n.cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = s.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;
endmodule // tdfr_tick

// ===== tdfr_top.sv
// Torque detection channel 1 and fault restart sequencer behind an AXI4-Lite slave
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "tdfr_defs.svh"

// What this block does
// - Flag detection only after crossing persists longer than the detection time.
// - Selection 0 disables; 1-4 overtorque; 5-8 undertorque.
// - Odd selections detect only at speed agree, never while ramping.
// - Even selections detect whenever the run command is active.
// - Selections 1,2,5,6 raise an alarm and keep the motor running.
// - Selections 3,4,7,8 raise a fault and stop the drive.
// - Detection level spans 0 to 300 percent, default 150.
// - Level refers to rated current or rated torque by control method.
// - A 10 percent band lies below the detection level for overtorque, above it for undertorque.
// - Analog input with function 11 overrides level 1; never level 2.
// - Output setting 18 follows detection 1; setting 20 follows detection 2.
// - Only the listed restartable faults start an automatic restart.
// - On shutdown withdraw the run command, then self-diagnose and clear.
// - Successful self-diagnosis restarts the motor with a speed search.
// - Attempt limit 0 to 10, default 0; at limit stop for manual clear.
// - Count clears after 10 minutes normal run, manual reset or power cycle.
// - Selection bit lets the fault output assert during restart; default off.
// - Interval between attempts 0.5 to 600.0 seconds, default 10.0.
// - Output setting 14 signals restart activity.
// - Detection time 0.0 to 10.0 seconds, default 0.1.
module tdfr_top import tdfr_pkg::*; #(
    parameter int unsigned TENTH_CYCLES = `TDFR_TENTH_NS / `TDFR_CLK_NS
) (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output logic s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire s_axi_rready,
    // Drive control core
    input tdfr_core_s core,
    input wire [8:0] anaLevel,
    input wire det2In,
    input wire [13:0] restartFault,
    input wire otherFault,
    input wire selfDiagDone,
    input wire selfDiagOk,
    input wire manualReset,
    // Drive commands and events
    output logic runWithdraw,
    output logic speedSearch,
    output logic driveStop,
    output logic overtorqueEvent1,
    output logic undertorqueEvent1,
    // Output terminals
    output logic faultOut,
    output logic restartActive,
    output logic [1:0] mfoOut
);
    tdfr_state_s s;
    tdfr_state_s n;
    logic detTick;
    logic seqTick;
    logic detClr;
    logic seqClr;
    logic [9:0] meas;
    logic [8:0] lvl;
    logic isOver;
    logic isUnder;
    logic isFaultSel;
    logic gateOk;
    logic cond;
    logic detFault;
    logic anyFault;
    logic [32:0] rd;
    logic [31:0] wmask;
    logic [31:0] wv;
    logic [6:0] nc;

    // --------------------------------------------------------------
    // Register access
    // --------------------------------------------------------------
    function automatic logic [32:0] regRead(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0;
        case (a)
            `TDFR_OFS_CTRL: begin
                d[`TDFR_F_SEL] = s.sel;
                d[`TDFR_F_FOSEL] = s.foSel;
                d[`TDFR_F_LIMIT] = s.limit;
                d[`TDFR_F_TREF] = s.torqueRef;
                d[`TDFR_F_ANA] = s.anaFunc;
            end
            `TDFR_OFS_LEVEL: d[`TDFR_F_LEVEL] = s.level;
            `TDFR_OFS_TIME: d[`TDFR_F_TIME] = s.dtime;
            `TDFR_OFS_IVL: d[`TDFR_F_IVL] = s.ivl;
            `TDFR_OFS_MFO: begin
                d[`TDFR_F_MFO0] = s.mfo0;
                d[`TDFR_F_MFO1] = s.mfo1;
            end
            `TDFR_OFS_STAT: begin
                d[0] = s.det1;
                d[1] = s.otEvt;
                d[2] = s.utEvt;
                d[3] = s.driveStop;
                d[4] = s.restartAct;
                d[5] = s.faultOut;
                d[`TDFR_F_ST] = s.st;
                d[`TDFR_F_CNT] = s.cnt;
                d[`TDFR_F_DCNT] = s.detCnt;
                d[`TDFR_F_MOUT] = s.mfoOut;
            end
            default: return {1'b0, 32'h0};
        endcase
        return {1'b1, d};
    endfunction

    function automatic logic mfoFn(input logic [4:0] f, input tdfr_state_s x);
        case (f)
            `TDFR_FN_FAULT: return x.faultOut;
            `TDFR_FN_RESTART: return x.restartAct;
            `TDFR_FN_DET1: return x.det1;
            `TDFR_FN_DET2: return det2In;
            default: return 1'b0;
        endcase
    endfunction

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    always_comb begin
        n = s;
        rd = 33'h0;
        wv = 32'h0;
        nc = 7'h0;
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{s.wstrb[b]}};
        end

        // Write channel: address and data are taken in either order
        if (s_axi_awvalid && s.awready) begin
            n.awHeld = 1'b1;
            n.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            n.wHeld = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.awHeld && s.wHeld && !s.bvalid) begin
            n.awHeld = 1'b0;
            n.wHeld = 1'b0;
            n.bvalid = 1'b1;
            rd = regRead(s.waddr);
            wv = (rd[31:0] & ~wmask) | (s.wdata & wmask);
            n.bresp = `TDFR_RESP_OKAY;
            // Out-of-range settings saturate, and an out-of-range selection becomes 0, so the logic never sees them
            case (s.waddr)
                `TDFR_OFS_CTRL: begin
                    n.sel = (wv[`TDFR_F_SEL] > `TDFR_SEL_MAX) ? 4'h0 : wv[`TDFR_F_SEL];
                    n.foSel = wv[`TDFR_F_FOSEL];
                    n.limit = (wv[`TDFR_F_LIMIT] > `TDFR_LIMIT_MAX) ? `TDFR_LIMIT_MAX : wv[`TDFR_F_LIMIT];
                    n.torqueRef = wv[`TDFR_F_TREF];
                    n.anaFunc = wv[`TDFR_F_ANA];
                end
                `TDFR_OFS_LEVEL: begin
                    n.level = (wv[`TDFR_F_LEVEL] > `TDFR_LEVEL_MAX) ? `TDFR_LEVEL_MAX : wv[`TDFR_F_LEVEL];
                end
                `TDFR_OFS_TIME: begin
                    n.dtime = (wv[`TDFR_F_TIME] > `TDFR_TIME_MAX) ? `TDFR_TIME_MAX : wv[`TDFR_F_TIME];
                end
                `TDFR_OFS_IVL: begin
                    n.ivl = wv[`TDFR_F_IVL];
                    if (wv[`TDFR_F_IVL] < `TDFR_IVL_MIN) begin
                        n.ivl = `TDFR_IVL_MIN;
                    end else if (wv[`TDFR_F_IVL] > `TDFR_IVL_MAX) begin
                        n.ivl = `TDFR_IVL_MAX;
                    end
                end
                `TDFR_OFS_MFO: begin
                    n.mfo0 = wv[`TDFR_F_MFO0];
                    n.mfo1 = wv[`TDFR_F_MFO1];
                end
                `TDFR_OFS_STAT: ;
                default: n.bresp = `TDFR_RESP_SLVERR;
            endcase
        end
        n.awready = !n.awHeld && !n.bvalid;
        n.wready = !n.wHeld && !n.bvalid;

        // Read channel: data follows the address by one edge
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            rd = regRead(s_axi_araddr);
            n.rvalid = 1'b1;
            n.rdata = rd[31:0];
            n.rresp = rd[32] ? `TDFR_RESP_OKAY : `TDFR_RESP_SLVERR;
        end
        n.arready = !n.rvalid;

        // --------------------------------------------------------------
        // Torque detection channel 1
        // --------------------------------------------------------------
        meas = s.torqueRef ? core.torque : core.current;
        lvl = s.level;
        if (s.anaFunc == `TDFR_ANA_LEVEL1) begin
            lvl = (anaLevel > `TDFR_LEVEL_MAX) ? `TDFR_LEVEL_MAX : anaLevel;
        end
        isOver = (s.sel >= 4'h1) && (s.sel <= 4'h4);
        isUnder = (s.sel >= 4'h5) && (s.sel <= `TDFR_SEL_MAX);
        isFaultSel = (s.sel == 4'h3) || (s.sel == 4'h4) || (s.sel == 4'h7) || (s.sel == 4'h8);
        gateOk = s.sel[0] ? (core.runCmd && core.speedAgree) : core.runCmd;
        // Once flagged, the crossing must retreat past the band to clear
        if (isOver) begin
            cond = s.det1 ? ({1'b0, meas} + `TDFR_BAND > {2'b0, lvl})
                          : (meas > {1'b0, lvl});
        end else begin
            cond = s.det1 ? ({1'b0, meas} < {2'b0, lvl} + `TDFR_BAND)
                          : (meas < {1'b0, lvl});
        end
        detClr = !((isOver || isUnder) && gateOk && cond);
        if (detClr) begin
            n.detCnt = 7'h0;
            n.det1 = 1'b0;
        end else if (detTick) begin
            nc = (s.detCnt == 7'h7f) ? s.detCnt : s.detCnt + 7'h1;
            n.detCnt = nc;
            if (nc > s.dtime) begin
                n.det1 = 1'b1;
            end
        end
        n.otEvt = n.det1 && isOver;
        n.utEvt = n.det1 && isUnder;
        detFault = s.det1 && isFaultSel;

        // --------------------------------------------------------------
        // Fault restart sequencer
        // --------------------------------------------------------------
        anyFault = (|restartFault) || detFault;
        case (s.st)
            ST_IDLE, ST_RUNNING: begin
                if (s.st == ST_RUNNING && seqTick) begin
                    n.tmr = s.tmr + 13'h1;
                    if (n.tmr >= `TDFR_NORMAL_TENTHS) begin
                        n.cnt = 4'h0;
                        n.st = ST_IDLE;
                    end
                end
                if (otherFault) begin
                    n.st = ST_LOCKOUT;
                end else if (anyFault) begin
                    // Limit checked before launch; limit 0 never retries
                    n.st = (s.cnt >= s.limit) ? ST_LOCKOUT : ST_WITHDRAW;
                end
            end
            ST_WITHDRAW: begin
                n.tmr = 13'h0;
                n.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (seqTick) begin
                    n.tmr = s.tmr + 13'h1;
                    if (n.tmr >= s.ivl) begin
                        n.st = ST_DIAG;
                    end
                end
            end
            ST_DIAG: begin
                if (selfDiagDone) begin
                    if (selfDiagOk) begin
                        n.cnt = s.cnt + 4'h1;
                        n.st = ST_SEARCH;
                    end else begin
                        n.st = ST_LOCKOUT;
                    end
                end
            end
            ST_SEARCH: begin
                n.tmr = 13'h0;
                n.st = ST_RUNNING;
            end
            ST_LOCKOUT: ;
            default: n.st = ST_IDLE;
        endcase
        if (manualReset) begin
            n.cnt = 4'h0;
            n.st = ST_IDLE;
        end
        seqClr = (n.st != s.st);

        // Outputs follow the state they will stand beside
        n.runWithdraw = (n.st == ST_WITHDRAW) || (n.st == ST_WAIT) || (n.st == ST_DIAG);
        n.speedSearch = (n.st == ST_SEARCH);
        n.restartAct = n.runWithdraw || n.speedSearch;
        n.driveStop = (n.st != ST_IDLE) && (n.st != ST_RUNNING);
        n.faultOut = (n.st == ST_LOCKOUT) || (n.restartAct && n.foSel);
        for (int i = 0; i < 2; i++) begin
            n.mfoOut[i] = mfoFn((i == 0) ? n.mfo0 : n.mfo1, n);
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s <= '0;
            s.st <= ST_IDLE;
            s.level <= `TDFR_LEVEL_RST;
            s.dtime <= `TDFR_TIME_RST;
            s.ivl <= `TDFR_IVL_RST;
        end else begin
            s <= n;
        end
    end

    // Two tick sources so each timer starts on a fresh phase
    tdfr_tick #(.PERIOD(TENTH_CYCLES)) u_det_tick (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clr(detClr),
        .tick(detTick)
    );

    tdfr_tick #(.PERIOD(TENTH_CYCLES)) u_seq_tick (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .clr(seqClr),
        .tick(seqTick)
    );

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign runWithdraw = s.runWithdraw;
    assign speedSearch = s.speedSearch;
    assign driveStop = s.driveStop;
    assign overtorqueEvent1 = s.otEvt;
    assign undertorqueEvent1 = s.utEvt;
    assign faultOut = s.faultOut;
    assign restartActive = s.restartAct;
    assign mfoOut = s.mfoOut;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_sel_disables: assert property (s.sel == 4'h0 |=> !s.det1)
        else $error("detection flagged while disabled");
    a_det_time: assert property ($rose(s.det1) |-> s.detCnt > $past(s.dtime))
        else $error("detection flagged before its time");
    a_agree_gate: assert property (s.sel[0] && !core.speedAgree |=> s.detCnt == 7'h0 && !s.det1)
        else $error("detection counted off speed agree");
    a_run_gate: assert property (!core.runCmd |=> !s.det1 ##1 !s.det1)
        else $error("detection held without run command");
    a_alarm_runs: assert property (s.det1 && !isFaultSel && s.st == ST_IDLE && restartFault == 14'h0
        && !otherFault |=> s.st == ST_IDLE && !s.driveStop)
        else $error("alarm selection stopped the drive");
    a_fault_stops: assert property (detFault && s.st == ST_IDLE && s.cnt < s.limit && !otherFault
        && !manualReset |=> s.runWithdraw && s.driveStop ##1 s.st == ST_WAIT)
        else $error("fault selection did not stop the drive");
    a_limit_lock: assert property (anyFault && s.st == ST_IDLE && s.cnt >= s.limit && !manualReset
        |=> s.st == ST_LOCKOUT && s.faultOut)
        else $error("restart launched beyond the limit");
    a_count_step: assert property ($rose(s.speedSearch) |-> s.cnt == $past(s.cnt) + 4'h1
        ##1 !s.speedSearch)
        else $error("attempt count did not step once");
    a_fault_quiet: assert property (s.restartAct && !s.foSel |-> !s.faultOut)
        else $error("fault output during restart while deselected");
    a_level_range: assert property (s.level <= `TDFR_LEVEL_MAX)
        else $error("level above range");
endmodule // tdfr_top

// ===== tdfr_core_model.sv
// Behavioural drive control core: restartable fault source and self-diagnosis responder
`timescale 1ns/1ns
module tdfr_core_model (
    // Clock
    input wire mclk,
    // Bench controls
    input wire inject,
    input wire [3:0] diagDelay,
    // From the block
    input wire runWithdraw,
    // To the block
    output logic [13:0] restartFault,
    output logic selfDiagDone,
    output logic selfDiagOk
);
    logic [3:0] waitCnt = 4'h0;

    initial begin
        restartFault = 14'h0000;
        selfDiagDone = 1'b0;
        selfDiagOk = 1'b0;
    end

    // Fault stays up until the run command is withdrawn, as a real trip would
    always @(posedge mclk) begin
        if (inject) begin
            restartFault <= 14'h0001;
        end else if (runWithdraw) begin
            restartFault <= 14'h0000;
        end
        waitCnt <= !runWithdraw ? 4'h0 : (waitCnt == diagDelay ? waitCnt : waitCnt + 4'h1);
        // Slow or prompt answer; result only meaningful once withdrawn
        selfDiagDone <= runWithdraw && waitCnt == diagDelay;
        selfDiagOk <= runWithdraw && waitCnt == diagDelay;
    end
endmodule // tdfr_core_model

// ===== torque_detect_fault_restart_bench.sv
// Self-checking bench for torque detection and fault restart
`timescale 1ns/1ns
`include "tdfr_defs.svh"
module torque_detect_fault_restart_bench import tdfr_pkg::*;;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h13668ecc, rd;
    logic [3:0] s_axi_wstrb = 4'hf, diagDelay = 4'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, mfoOut;
    tdfr_core_s core = '0;
    logic [8:0] anaLevel = '0, lv;
    logic [9:0] mv, ov;
    logic det2In = 0, manualReset = 0, inject = 0, tr;
    logic [13:0] restartFault;
    logic selfDiagDone, selfDiagOk, runWithdraw, speedSearch, driveStop;
    logic overtorqueEvent1, undertorqueEvent1, faultOut, restartActive;
    int numErrors = 0, nTests = 0, cyc = 0, n, sl, k;

    always #20 mclk = ~mclk;

    tdfr_top #(.TENTH_CYCLES(10)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .core(core), .anaLevel(anaLevel),
        .det2In(det2In), .restartFault(restartFault), .otherFault(1'b0), .selfDiagDone(selfDiagDone),
        .selfDiagOk(selfDiagOk), .manualReset(manualReset), .runWithdraw(runWithdraw),
        .speedSearch(speedSearch), .driveStop(driveStop), .overtorqueEvent1(overtorqueEvent1),
        .undertorqueEvent1(undertorqueEvent1), .faultOut(faultOut), .restartActive(restartActive),
        .mfoOut(mfoOut));

    // A stopped drive ends the trip too, so a lockout does not refire after manual reset
    tdfr_core_model u_core (.mclk(mclk), .inject(inject), .diagDelay(diagDelay),
        .runWithdraw(runWithdraw || driveStop), .restartFault(restartFault), .selfDiagDone(selfDiagDone),
        .selfDiagOk(selfDiagOk));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic nxt;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            numErrors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask

    // Idle cycle first so no handshake signal is assigned twice in one step
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic clearAll;
        core <= '0;
        manualReset <= 1'b1;
        tick(1);
        manualReset <= 1'b0;
        tick(2);
    endtask

    // {driveStop, under, over} expected for a selection
    function automatic logic [2:0] expDet(input int s);
        return {s inside {3, 4, 7, 8}, s >= 5, s >= 1 && s <= 4};
    endfunction

    task automatic wrapUp;
        $display("comparisons %0d, mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run needs a few hundred cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            numErrors++;
            wrapUp();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        tick(2);
        sys_rst <= 1'b0;
        tick(2);
        axr(`TDFR_OFS_CTRL); chk(rd, 32'h0);
        axr(`TDFR_OFS_LEVEL); chk(rd, 32'(`TDFR_LEVEL_RST));
        axr(`TDFR_OFS_TIME); chk(rd, 32'(`TDFR_TIME_RST));
        axr(`TDFR_OFS_IVL);
        chk(rd, 32'(`TDFR_IVL_RST));
        $display("test reset values done");
        // Level never crossed by the unselected quantity
        ov = 10'(`TDFR_LEVEL_RST);
        axw(`TDFR_OFS_MFO, {19'h0, `TDFR_FN_RESTART, 3'h0, `TDFR_FN_DET1});
        // Corner selection 8 first, then random ones
        for (n = 0; n < 4; n++) begin
            nxt();
            sl = (n == 0) ? 8 : seed % 8 + 1;
            tr = seed[8];
            mv = (sl >= 5) ? 10'(seed[15:9] % 140) : 10'(151 + seed[15:9] % 100);
            axw(`TDFR_OFS_CTRL, 32'(sl) | (32'(tr) << `TDFR_F_TREF));
            core <= '{1'b1, 1'b1, tr ? ov : mv, tr ? mv : ov};
            tick(5);
            chk({driveStop, undertorqueEvent1, overtorqueEvent1}, 3'h0);
            tick(25);
            chk({driveStop, undertorqueEvent1, overtorqueEvent1}, expDet(sl));
            chk(mfoOut[0], 1);
            // Back inside the band the flag must hold
            mv = (sl >= 5) ? ov + 10'h5 : ov - 10'h5;
            core <= '{1'b1, 1'b1, tr ? ov : mv, tr ? mv : ov};
            tick(3);
            chk(overtorqueEvent1 | undertorqueEvent1, 1);
            core.speedAgree <= 1'b0;
            tick(3);
            chk(overtorqueEvent1 | undertorqueEvent1, 32'(!sl[0]));
            clearAll();
        end
        $display("test detection done");
        nxt();
        tr = seed[0];
        sl = 5 + seed[2:1];
        diagDelay <= seed[6:3];
        axw(`TDFR_OFS_IVL, 32'(sl));
        // Limit of two attempts; the third fault locks out
        axw(`TDFR_OFS_CTRL, 32'h200 | (32'(tr) << `TDFR_F_FOSEL));
        for (n = 0; n < 3; n++) begin
            inject <= 1'b1;
            tick(1);
            inject <= 1'b0;
            tick(3);
            chk({restartActive, mfoOut[1], faultOut}, (n < 2) ? {2'h3, tr} : 3'h1);
            chk(runWithdraw, 32'(n < 2));
            k = 0;
            while (!speedSearch && k < 100) begin
                tick(1);
                k++;
            end
            chk(32'(k >= sl * 10 && k <= sl * 10 + 5), 32'(n < 2));
            axr(`TDFR_OFS_STAT);
            chk(rd[`TDFR_F_CNT], (n < 2) ? n + 1 : 2);
        end
        clearAll();
        axr(`TDFR_OFS_STAT);
        chk(rd[`TDFR_F_CNT], 0);
        $display("test restart done");
        wrapUp();
    end
endmodule // torque_detect_fault_restart_bench
